//--- bench/sit_bus_model.sv
// Bus partner that clocks bytes and signals stop on the wires
`timescale 1ns/1ps
module sit_bus_model (
	input  wire logic scl_i,     // Clock line level
	output logic      scl_low_o, // Pulls clock low
	output logic      sda_low_o  // Pulls data low
);
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic pulses(input int n);
		repeat (n) begin
			scl_low_o = 1'b1;
			#200;
			scl_low_o = 1'b0;
			for (int w = 0; w < 40 && !scl_i; w++) #10;
			#200;
		end
	endtask : pulses
	task automatic stop();
		sda_low_o = 1'b1;
		#200;
		sda_low_o = 1'b0;
		#200;
	endtask : stop
endmodule : sit_bus_model

//--- bench/sit_ctrl_asserts.sv
// Port assertions for the timing control block
`timescale 1ns/1ps
module sit_ctrl_asserts (
	input wire logic                  clock_i,     // System clock
	input wire logic                  sys_rst_i,   // Sync reset
	input wire sit_pkg::sit_cpu_req_t cpu_req_i,   // CPU write
	input wire logic [7:0]            cpu_rdata_o, // Read data
	input wire logic                  serial_channel_enable_i, // On
	input wire logic [7:0]            slave_address_register_i, // Own
	input wire logic [7:0]            rx_addr_i,   // Received
	input wire logic                  serial_clock_pin_oe_o, // Drive
	input wire logic                  channel_interrupt_request_o, // Req
	input wire logic                  channel_interrupt_flag_o, // Flag
	input wire logic                  addr_match_o, // Match
	input wire logic                  xfer_active_o, // Busy
	input wire logic                  wait_hold_o  // Wait
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire idle = serial_channel_enable_i && !xfer_active_o && !wait_hold_o;
	a_reset_zero: assert property (
		$fell(sys_rst_i) |-> cpu_rdata_o == 8'h00)
		else $error("register not clear after reset");
	a_top_bit: assert property (
		cpu_rdata_o[7] == 1'b0)
		else $error("bit 7 not zero");
	a_level_off: assert property (
		(!serial_channel_enable_i)[*3] |-> !cpu_rdata_o[6])
		else $error("level bit set while disabled");
	a_req_pulse: assert property (
		channel_interrupt_request_o |=> !channel_interrupt_request_o)
		else $error("request longer than one cycle");
	a_flag_follows: assert property (
		channel_interrupt_request_o |-> ##[0:1] channel_interrupt_flag_o)
		else $error("flag not set by request");
	a_wait_drives: assert property (
		wait_hold_o |-> serial_clock_pin_oe_o)
		else $error("clock released during wait");
	a_wait_mode: assert property (
		$rose(wait_hold_o) |-> cpu_rdata_o[1])
		else $error("wait entered without wait mode");
	a_wait_ends: assert property (
		$fell(wait_hold_o) && serial_channel_enable_i
		|-> ##[0:1] cpu_rdata_o[2])
		else $error("wait left without release");
	a_rel_clears: assert property (
		cpu_rdata_o[2] |=> !cpu_rdata_o[2])
		else $error("release bit not cleared");
	// Read image trails the pin enable by one cycle
	a_idle_low: assert property (
		(idle && !cpu_rdata_o[3])[*3] |-> $past(serial_clock_pin_oe_o))
		else $error("idle clock not driven low");
	a_idle_float: assert property (
		(idle && cpu_rdata_o[3])[*3] |-> !$past(serial_clock_pin_oe_o))
		else $error("idle clock not released");
	a_mask_cmp: assert property (
		(!cpu_req_i.wr)[*3] |-> addr_match_o ==
		(((slave_address_register_i ^ rx_addr_i)
		& {7'h7f, !cpu_rdata_o[4]}) == 8'h00))
		else $error("address compare wrong");
endmodule : sit_ctrl_asserts

//--- bench/tb_top.sv
// Self-checking bench for the timing control block
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] A = sit_pkg::SIT_REG_ADDR;
	sit_pkg::sit_cpu_req_t req = '0;
	logic       clock_i = 1'b0, lclk = 1'b0, rst = 1'b1;
	logic       en = 1'b0, wake = 1'b0, start = 1'b0, clr = 1'b0, rxv = 1'b0;
	logic [7:0] slave_address_register = 8'h00, rxa = 8'h00, rdata, img = 8'h00, d, mk;
	logic       oe, po, irq, flag, match, act, hold, scl, sl, dl;
	logic [31:0] rs = 32'd75;
	int         mismatches = 0, comparisons = 0, reqs = 0;
	// Open-drain line with pull-up: low while either side pulls
	assign scl = (oe ? po : 1'b1) & !sl;
	always #5 clock_i = ~clock_i;
	initial begin
		#3.7;
		forever #15 lclk = ~lclk;
	end
	always @(posedge clock_i) if (irq === 1'b1) reqs++;
	sit_ctrl sit_ctrl_i (.clock_i(clock_i), .sys_rst_i(rst), .link_clk_i(lclk),
		.cpu_req_i(req), .cpu_rdata_o(rdata), .serial_channel_enable_i(en),
		.wake_up_enable_i(wake), .start_xfer_i(start), .master_drive_i(1'b0),
		.slave_address_register_i(slave_address_register), .rx_addr_i(rxa), .rx_addr_valid_i(rxv),
		.flag_clear_i(clr), .serial_clock_pin_i(scl), .serial_clock_pin_o(po),
		.serial_clock_pin_oe_o(oe), .serial_data_pin_i(!dl),
		.channel_interrupt_request_o(irq), .channel_interrupt_flag_o(flag),
		.addr_match_o(match), .xfer_active_o(act), .wait_hold_o(hold));
	sit_bus_model sit_bus_model_i (.scl_i(scl), .scl_low_o(sl), .sda_low_o(dl));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd
	// Release bit excluded, it clears itself
	function automatic logic [7:0] exp_reg(logic [7:0] o, v, m);
		return ((o & ~m) | (v & m)) & 8'h3b;
	endfunction : exp_reg
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : cyc
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] v, m);
		req = '{1'b1, a, v, m};
		cyc(1);
		req.wr = 1'b0;
		if (a == A) img = exp_reg(img, v, m);
		cyc(3);
	endtask : wr
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clock_i);
		#1;
		rst = 1'b0;
		cyc(2);
		check(rdata, 8'h00);
		en = 1'b1;
		for (int k = 0; k < 12; k++) begin
			d  = 8'(rnd());
			mk = (k < 4) ? 8'hff : 8'h01 << (k % 8);
			// wait pair never zero-one, bit writes too
			if (mk[1])
				d[1] = d[1] | (mk[0] ? d[0] : img[0]);
			else if (mk[0])
				d[0] = d[0] & img[1];
			wr((k == 5) ? A + 16'h1 : A, d, mk);
			check(rdata & 8'hbb, img);
		end
		$display("test writes done");
		wr(A, 8'h08, 8'hff);
		check(rdata, img | 8'h40);
		check({7'h00, oe}, 8'h00);
		wr(A, 8'h40, 8'hff);
		check(rdata, 8'h00);
		check({7'h00, oe}, 8'h01);
		$display("test levels done");
		for (int md = 0; md < 4; md++) if (md != 1) begin
			wr(A, 8'h08 | 8'(md), 8'hff);
			start = 1'b1;
			cyc(1);
			start = 1'b0;
			reqs = 0;
			sit_bus_model_i.pulses((md == 3) ? 8 : 7);
			check(8'(reqs), 8'h00);
			sit_bus_model_i.pulses(1);
			cyc(10);
			check(8'(reqs), 8'h01);
			check({7'h00, hold}, {7'h00, md[1]});
			check({7'h00, oe}, {7'h00, md[1]});
			if (md == 3) begin
				start = 1'b1;
				cyc(1);
				start = 1'b0;
				cyc(20);
				check({6'h00, act, hold}, 8'h01);
			end
			wr(A, 8'h04, 8'h04);
			check({7'h00, hold}, 8'h00);
		end
		check({7'h00, act}, 8'h01);
		en = 1'b0;
		cyc(4);
		check(rdata & 8'h40, 8'h00);
		en = 1'b1;
		$display("test waits done");
		for (int s = 1; s >= 0; s--) begin
			wr(A, s ? 8'h28 : 8'h08, 8'hff);
			reqs = 0;
			sit_bus_model_i.stop();
			cyc(10);
			check(8'(reqs), 8'(s));
		end
		wake = 1'b1;
		for (int s = 1; s >= 0; s--) begin
			wr(A, s ? 8'h38 : 8'h28, 8'hff);
			slave_address_register = 8'(rnd());
			rxa = slave_address_register ^ 8'h01;
			reqs = 0;
			rxv = 1'b1;
			cyc(1);
			rxv = 1'b0;
			check({7'h00, match}, 8'(s));
			cyc(3);
			check(8'(reqs), 8'(s));
		end
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(1);
		check({7'h00, flag}, 8'h00);
		$display("test events done");
		end_sim();
	end
endmodule : tb_top
bind sit_ctrl sit_ctrl_asserts sit_ctrl_asserts_i (.clock_i(clock_i),
	.sys_rst_i(sys_rst_i), .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o),
	.serial_channel_enable_i(serial_channel_enable_i),
	.slave_address_register_i(slave_address_register_i),
	.rx_addr_i(rx_addr_i), .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
	.channel_interrupt_request_o(channel_interrupt_request_o),
	.channel_interrupt_flag_o(channel_interrupt_flag_o),
	.addr_match_o(addr_match_o), .xfer_active_o(xfer_active_o),
	.wait_hold_o(wait_hold_o));

//--- inc/sit_pkg.sv
// Package for the interrupt timing and wait control block
package sit_pkg;

	// Register address and width
	localparam logic [15:0] SIT_REG_ADDR   = 16'hff63;
	localparam int          SIT_REG_W      = 8;
	localparam logic [7:0]  SIT_REG_RESET  = 8'h00;

	// Field positions
	localparam int SIT_WAIT_LOW_BIT  = 0;
	localparam int SIT_WAIT_HIGH_BIT = 1;
	localparam int SIT_WAIT_RELEASE_BIT      = 2;
	localparam int SIT_CLC_BIT       = 3;
	localparam int SIT_ADDRESS_MASK_SELECT_BIT      = 4;
	localparam int SIT_SIC_BIT       = 5;
	localparam int SIT_CLD_BIT       = 6;
	localparam int SIT_RSVD_BIT      = 7;

	// Bits that software may store; level sense and bit 7 excluded
	localparam logic [7:0] SIT_WR_MASK = 8'h3f;

	// Serial clock counts that end a byte
	localparam logic [3:0] SIT_CNT_8 = 4'h8;
	localparam logic [3:0] SIT_CNT_9 = 4'h9;

	// Wait select encodings
	localparam logic [1:0] SIT_MODE_NOWAIT = 2'h0;
	localparam logic [1:0] SIT_MODE_BAD    = 2'h1;
	localparam logic [1:0] SIT_MODE_WAIT8  = 2'h2;
	localparam logic [1:0] SIT_MODE_WAIT9  = 2'h3;

	// CPU access to the register
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  wmask;
	} sit_cpu_req_t;

	// Stored control fields
	typedef struct packed {
		logic       interrupt_source_select;
		logic       address_mask_select;
		logic       clock_level_control;
		logic       wait_release;
		logic [1:0] wait_sel;
	} sit_ctrl_t;

	// Channel states, one-hot
	typedef enum logic [2:0] {
		SIT_IDLE = 3'h1,
		SIT_XFER = 3'h2,
		SIT_WAIT = 3'h4
	} sit_state_t;

endpackage : sit_pkg

//--- verilog/sit_ctrl.sv
// Interrupt timing and wait control, system clock side
// How it works
// - Reset clears the register to zero
// - CPU writes single bits or whole byte
// - Mode zero: interrupt at eighth edge
// - Eight-clock wait: interrupt, hold clock low
// - Nine-clock wait: interrupt, hold clock low
// - Release bit ends wait, self-clears
// - Level bit zero drives idle clock low
// - Level bit one floats idle clock
// - Mask bit drops address bit zero
// - Source bit adds stop to flag
// - Bit six reads clock pin, read-only
// - Channel disabled reads level as zero
// - Stop is data rising, clock high
// - Wake-up flags only on address match
`timescale 1ns/1ps
module sit_ctrl (
	input  wire logic                clock_i,        // System clock
	input  wire logic                sys_rst_i,      // Sync reset, high
	input  wire logic                link_clk_i,     // Link sampling clock
	input  wire sit_pkg::sit_cpu_req_t cpu_req_i,    // CPU write access
	output logic [7:0]               cpu_rdata_o,    // Register read data
	input  wire logic                serial_channel_enable_i, // Channel on
	input  wire logic                wake_up_enable_i,   // Wake-up mode
	input  wire logic                start_xfer_i,   // Transfer start pulse
	input  wire logic                master_drive_i, // Master clock low
	input  wire logic [7:0]          slave_address_register_i, // Own addr
	input  wire logic [7:0]          rx_addr_i,      // Received address
	input  wire logic                rx_addr_valid_i, // Address strobe
	input  wire logic                flag_clear_i,   // Clear flag pulse
	input  wire logic                serial_clock_pin_i, // Clock pin level
	output logic                     serial_clock_pin_o, // Clock pin value
	output logic                     serial_clock_pin_oe_o, // Clock drive
	input  wire logic                serial_data_pin_i, // Data pin level
	output logic                     channel_interrupt_request_o, // Pulse
	output logic                     channel_interrupt_flag_o, // Sticky
	output logic                     addr_match_o,   // Address compare
	output logic                     xfer_active_o,  // Transfer running
	output logic                     wait_hold_o     // Wait state held
);
	sit_pkg::sit_ctrl_t  ctrl_q;
	sit_pkg::sit_ctrl_t  ctrl_d;
	sit_pkg::sit_state_t state_q;
	sit_pkg::sit_state_t state_d;
	logic [1:0]          scl_s_q;
	logic [2:0]          end_s_q;
	logic [2:0]          stop_s_q;
	logic                pending_q;
	logic                end_tgl;
	logic                stop_tgl;
	logic                end_evt;
	logic                stop_evt;
	logic                reg_sel;
	logic                release_now;
	logic                irq_set;
	logic                level_sense;
	logic [7:0]          wr_bits;
	logic [7:0]          cur_bits;

	// Address compare, optionally ignoring bit zero
	function automatic logic addr_eq(input logic [7:0] a,
	                                 input logic [7:0] b,
	                                 input logic       drop0);
		logic [7:0] m;
		m = drop0 ? 8'hfe : 8'hff;
		return ((a & m) == (b & m));
	endfunction : addr_eq

	// Current stored fields as a byte
	function automatic logic [7:0] pack_bits(input sit_pkg::sit_ctrl_t c);
		logic [7:0] v;
		v = 8'h00;
		v[sit_pkg::SIT_WAIT_LOW_BIT]  = c.wait_sel[0];
		v[sit_pkg::SIT_WAIT_HIGH_BIT] = c.wait_sel[1];
		v[sit_pkg::SIT_WAIT_RELEASE_BIT]      = c.wait_release;
		v[sit_pkg::SIT_CLC_BIT]       = c.clock_level_control;
		v[sit_pkg::SIT_ADDRESS_MASK_SELECT_BIT]      = c.address_mask_select;
		v[sit_pkg::SIT_SIC_BIT]       = c.interrupt_source_select;
		return v;
	endfunction : pack_bits

	sit_link u_link (
		.link_clk_i (link_clk_i),
		.sys_rst_i  (sys_rst_i),
		.active_i   (state_q == sit_pkg::SIT_XFER),
		.nine_i     (ctrl_q.wait_sel == sit_pkg::SIT_MODE_WAIT9),
		.scl_i      (serial_clock_pin_i),
		.sda_i      (serial_data_pin_i),
		.end_tgl_o  (end_tgl),
		.stop_tgl_o (stop_tgl)
	);

	// Pin level and link events cross on two flops
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			scl_s_q  <= 2'h3;
			end_s_q  <= 3'h0;
			stop_s_q <= 3'h0;
		end else begin
			scl_s_q  <= {scl_s_q[0], serial_clock_pin_i};
			end_s_q  <= {end_s_q[1:0], end_tgl};
			stop_s_q <= {stop_s_q[1:0], stop_tgl};
		end
	end

	assign end_evt  = end_s_q[2] ^ end_s_q[1];
	assign stop_evt = stop_s_q[2] ^ stop_s_q[1];

	assign reg_sel  = cpu_req_i.wr
	               && (cpu_req_i.addr == sit_pkg::SIT_REG_ADDR);
	assign cur_bits = pack_bits(ctrl_q);

	assign wr_bits = (cur_bits & ~cpu_req_i.wmask)
	               | (cpu_req_i.wdata & cpu_req_i.wmask);

	assign release_now = ctrl_q.wait_release;

	always_comb begin
		ctrl_d = ctrl_q;
		if (reg_sel) begin
			ctrl_d.wait_sel[0] = wr_bits[sit_pkg::SIT_WAIT_LOW_BIT];
			ctrl_d.wait_sel[1] = wr_bits[sit_pkg::SIT_WAIT_HIGH_BIT];
			ctrl_d.clock_level_control         = wr_bits[sit_pkg::SIT_CLC_BIT];
			ctrl_d.address_mask_select        = wr_bits[sit_pkg::SIT_ADDRESS_MASK_SELECT_BIT];
			ctrl_d.interrupt_source_select         = wr_bits[sit_pkg::SIT_SIC_BIT];
		end
		// Release bit self-clears
		// A write of one in the cycle a release completes is dropped
		if (reg_sel && wr_bits[sit_pkg::SIT_WAIT_RELEASE_BIT] && !release_now)
			ctrl_d.wait_release = 1'b1;
		else if (release_now)
			ctrl_d.wait_release = 1'b0;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			ctrl_q <= sit_pkg::sit_ctrl_t'(sit_pkg::SIT_REG_RESET[5:0]);
		else
			ctrl_q <= ctrl_d;
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sit_pkg::SIT_IDLE: begin
				if (start_xfer_i || pending_q)
					state_d = sit_pkg::SIT_XFER;
			end
			sit_pkg::SIT_XFER: begin
				if (end_evt && ctrl_q.wait_sel[1])
					state_d = sit_pkg::SIT_WAIT;
				else if (end_evt)
					state_d = sit_pkg::SIT_IDLE;
			end
			sit_pkg::SIT_WAIT: begin
				if (release_now)
					state_d = (pending_q || start_xfer_i)
					        ? sit_pkg::SIT_XFER : sit_pkg::SIT_IDLE;
			end
			default: state_d = sit_pkg::SIT_IDLE;
		endcase
		if (!serial_channel_enable_i)
			state_d = sit_pkg::SIT_IDLE;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			state_q <= sit_pkg::SIT_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || !serial_channel_enable_i)
			pending_q <= 1'b0;
		else if (state_d == sit_pkg::SIT_XFER)
			pending_q <= 1'b0;
		else if (start_xfer_i)
			pending_q <= 1'b1;
	end

	assign addr_match_o = addr_eq(rx_addr_i, slave_address_register_i,
	                              ctrl_q.address_mask_select);

	always_comb begin
		irq_set = 1'b0;
		if (wake_up_enable_i)
			irq_set = rx_addr_valid_i && addr_match_o;
		else
			irq_set = end_evt || (stop_evt && ctrl_q.interrupt_source_select);
		if (!serial_channel_enable_i)
			irq_set = 1'b0;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			channel_interrupt_request_o <= 1'b0;
		else
			channel_interrupt_request_o <= irq_set;
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			channel_interrupt_flag_o <= 1'b0;
		else if (irq_set)
			channel_interrupt_flag_o <= 1'b1;
		else if (flag_clear_i)
			channel_interrupt_flag_o <= 1'b0;
	end

	// Open drain: pin value is always low, only the enable moves
	assign serial_clock_pin_o = 1'b0;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			serial_clock_pin_oe_o <= 1'b0;
		else if (!serial_channel_enable_i)
			serial_clock_pin_oe_o <= 1'b0;
		else if (state_d == sit_pkg::SIT_WAIT)
			serial_clock_pin_oe_o <= 1'b1;
		else if (state_d == sit_pkg::SIT_XFER)
			serial_clock_pin_oe_o <= master_drive_i;
		else
			serial_clock_pin_oe_o <= ~ctrl_d.clock_level_control;
	end

	assign xfer_active_o = (state_q == sit_pkg::SIT_XFER);
	assign wait_hold_o   = (state_q == sit_pkg::SIT_WAIT);

	assign level_sense = serial_channel_enable_i & scl_s_q[1];

	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			cpu_rdata_o <= 8'h00;
		else begin
			cpu_rdata_o <= cur_bits;
			cpu_rdata_o[sit_pkg::SIT_CLD_BIT]  <= level_sense;
			cpu_rdata_o[sit_pkg::SIT_RSVD_BIT] <= 1'b0;
		end
	end

endmodule : sit_ctrl

//--- verilog/sit_link.sv
// Link-domain serial clock counter and stop detector
`timescale 1ns/1ps
module sit_link (
	input  wire logic link_clk_i,   // Link sampling clock
	input  wire logic sys_rst_i,    // System reset, synced here
	input  wire logic active_i,     // Transfer active, system domain
	input  wire logic nine_i,       // Nine-clock mode, system domain
	input  wire logic scl_i,        // Serial clock pin level
	input  wire logic sda_i,        // Serial data pin level
	output logic      end_tgl_o,    // Toggles at byte end
	output logic      stop_tgl_o    // Toggles on stop condition
);
	logic [1:0] rst_s_q;
	logic [1:0] act_s_q;
	logic [1:0] nine_s_q;
	logic [1:0] scl_s_q;
	logic [1:0] sda_s_q;
	logic       scl_p_q;
	logic       sda_p_q;
	logic [3:0] cnt_q;
	logic       done_q;
	logic       rst;
	logic [3:0] target;

	// Every input here is foreign to this clock
	always_ff @(posedge link_clk_i) begin
		rst_s_q  <= {rst_s_q[0], sys_rst_i};
		act_s_q  <= {act_s_q[0], active_i};
		nine_s_q <= {nine_s_q[0], nine_i};
		scl_s_q  <= {scl_s_q[0], scl_i};
		sda_s_q  <= {sda_s_q[0], sda_i};
	end

	assign rst    = rst_s_q[1];
	assign target = nine_s_q[1] ? sit_pkg::SIT_CNT_9 : sit_pkg::SIT_CNT_8;

	always_ff @(posedge link_clk_i) begin
		if (rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s_q[1];
			sda_p_q <= sda_s_q[1];
		end
	end

	// Count rising edges
	// Counter sleeps outside transfers, so stray edges do not count
	always_ff @(posedge link_clk_i) begin
		if (rst || !act_s_q[1]) begin
			cnt_q  <= 4'h0;
			done_q <= 1'b0;
		end else if (scl_s_q[1] && !scl_p_q && !done_q) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q + 4'h1 == target)
				done_q <= 1'b1;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (rst)
			end_tgl_o <= 1'b0;
		else if (act_s_q[1] && !done_q && scl_s_q[1] && !scl_p_q
			 && (cnt_q + 4'h1 == target))
			end_tgl_o <= ~end_tgl_o;
	end

	always_ff @(posedge link_clk_i) begin
		if (rst)
			stop_tgl_o <= 1'b0;
		else if (sda_s_q[1] && !sda_p_q && scl_s_q[1] && scl_p_q)
			stop_tgl_o <= ~stop_tgl_o;
	end

endmodule : sit_link
